// ### hw/mci_pkg.sv
// shared constants and carriers for the motor command frame interpreter
// assumes one clock domain and byte streams already framed by a link layer
package mci_pkg;

  // frame geometry
  localparam logic [3:0]  SERIAL_LAST_POS = 4'h8;
  localparam logic [3:0]  CAN_LAST_POS    = 4'h7;
  localparam logic [3:0]  SUM_POS         = 4'h8;
  localparam logic [3:0]  SERIAL_REPLY_LEN = 4'h9;
  localparam logic [3:0]  CAN_REPLY_LEN    = 4'h7;

  // reply status codes
  localparam logic [7:0]  STATUS_OK        = 8'h64;
  localparam logic [7:0]  STATUS_STORED    = 8'h65;
  localparam logic [7:0]  STATUS_CHECKSUM  = 8'h01;
  localparam logic [7:0]  STATUS_BAD_CMD   = 8'h02;
  localparam logic [7:0]  STATUS_BAD_TYPE  = 8'h03;
  localparam logic [7:0]  STATUS_BAD_VALUE = 8'h04;
  localparam logic [7:0]  STATUS_LOCKED    = 8'h05;
  localparam logic [7:0]  STATUS_NOT_AVAIL = 8'h06;

  // axis setting numbers and limits
  localparam logic [7:0]  SETTING_SPEED    = 8'h04;
  localparam logic [7:0]  SETTING_ACCEL    = 8'h05;
  localparam logic [7:0]  SETTING_RUN_CUR  = 8'h06;
  localparam logic [7:0]  SETTING_STBY_CUR = 8'h07;
  localparam logic [31:0] RAMP_MAX         = 32'h0000_07ff;
  localparam logic [31:0] CURRENT_MAX      = 32'h0000_00ff;

  // reset values of the axis settings
  localparam logic [10:0] SPEED_RESET      = 11'h000;
  localparam logic [10:0] ACCEL_RESET      = 11'h000;
  localparam logic [7:0]  RUN_CUR_RESET    = 8'h00;
  localparam logic [7:0]  STBY_CUR_RESET   = 8'h00;

  // receive buffer shape
  localparam int          FIFO_WIDTH = 8;
  localparam int          FIFO_DEPTH = 8;

  typedef enum logic [1:0] {
    MCI_RX,
    MCI_EXEC,
    MCI_TX
  } mci_phase_t;

  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  kind;
    logic [7:0]  bank;
    logic [31:0] value;
  } mci_cmd_t;

  typedef struct packed {
    logic [10:0] max_speed;
    logic [10:0] max_accel;
    logic [7:0]  run_current;
    logic [7:0]  standby_current;
  } mci_axis_t;

endpackage

// ### hw/mci_fifo.sv
// small synchronous fifo with valid and ready on both sides
// assumes depth is a power of two and a single clock
`timescale 1ns/1ps
module mci_fifo #(
  parameter int WIDTH = mci_pkg::FIFO_WIDTH,
  parameter int DEPTH = mci_pkg::FIFO_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 count;
  } mci_fifo_state_t;

  mci_fifo_state_t st;
  mci_fifo_state_t next_st;
  logic            push;
  logic            pop;

  assign in_ready  = (st.count != (AW+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data  = st.mem[st.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data;
      next_st.wp = st.wp + AW'(1);
    end
    if (pop) begin
      next_st.rp = st.rp + AW'(1);
    end
    if (push && !pop) begin
      next_st.count = st.count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_st.count = st.count - (AW+1)'(1);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ### hw/mci_interp.sv
// command frame interpreter: parses host frames, runs them, sends one reply
// assumes byte streams from a link layer on the same clock, link type static
// What this block does
// - command core is code, type, selector and four value bytes, seven in all.
// - serial and usb frames add a leading address and trailing checksum, nine bytes.
// - order is address, code, type, selector, value msb first, checksum.
// - checksum is the 8-bit sum of the eight preceding bytes, verified here.
// - can frames carry no address or checksum; identifier gives the address.
// - after executing a host command exactly one reply is sent.
// - bus is driven only while answering a received command.
// - setting 4 holds maximum positioning speed, 0 to 2047, read and write.
// - setting 5 holds maximum acceleration, 0 to 2047, read and write.
// - setting 6 holds running current, 0 to 255 full scale.
// - setting 7 holds standstill current, 0 to 255 full scale.
// - commands come from host or from a stored program entry.
// - serial reply is reply address, address, status, code, value, checksum.
// - status 100 ok, 101 stored, 1 to 6 for the error cases.
// - can replies drop reply address and checksum bytes.
`timescale 1ns/1ps
module mci_interp #(
  parameter logic [7:0] SET_SETTING_CODE = 8'h01,
  parameter logic [7:0] GET_SETTING_CODE = 8'h02,
  parameter logic [7:0] MOVE_CODE        = 8'h03,
  parameter logic [7:0] HALT_CODE        = 8'h04
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             rx_valid,
  output logic                  rx_ready,
  input  wire logic [7:0]       rx_data,
  output logic                  tx_valid,
  input  wire logic             tx_ready,
  output logic [7:0]            tx_data,
  output logic                  bus_drive,
  input  wire logic             link_can,
  input  wire logic [7:0]       module_addr,
  input  wire logic [7:0]       reply_addr,
  input  wire logic             store_mode,
  input  wire logic             settings_locked,
  input  wire logic             prog_valid,
  output logic                  prog_ready,
  input  wire mci_pkg::mci_cmd_t prog_cmd,
  output logic                  store_valid,
  output mci_pkg::mci_cmd_t     store_cmd,
  output logic                  move_start,
  output logic [31:0]           move_target,
  output logic                  motor_halt,
  output logic [10:0]           max_speed,
  output logic [10:0]           max_accel,
  output logic [7:0]            run_current,
  output logic [7:0]            standby_current
);

  typedef struct packed {
    mci_pkg::mci_phase_t phase;
    logic [3:0]          cnt;
    logic                can;
    logic                from_prog;
    logic [8:0][7:0]     frame;
    logic [7:0]          sum;
    mci_pkg::mci_cmd_t   cmd;
    mci_pkg::mci_axis_t  axis;
    logic [8:0][7:0]     reply;
    logic [3:0]          rlen;
    logic                drive;
    logic                move;
    logic [31:0]         target;
    logic                halt;
    logic                store;
    mci_pkg::mci_cmd_t   store_cmd;
  } mci_state_t;

  mci_state_t st;
  mci_state_t next_st;
  logic       f_valid;
  logic       f_ready;
  logic [7:0] f_data;

  mci_fifo #(
    .WIDTH(mci_pkg::FIFO_WIDTH),
    .DEPTH(mci_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clock    (clock),
    .reset_n  (reset_n),
    .in_valid (rx_valid),
    .in_ready (rx_ready),
    .in_data  (rx_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data (f_data)
  );

  // host bytes stall in the fifo while a command runs or replies
  assign f_ready    = (st.phase == mci_pkg::MCI_RX);
  assign prog_ready = (st.phase == mci_pkg::MCI_RX) && (st.cnt == 4'h0) && !f_valid;
  assign tx_valid   = (st.phase == mci_pkg::MCI_TX);
  assign tx_data    = st.reply[0];
  assign bus_drive  = st.drive;
  assign store_valid = st.store;
  assign store_cmd   = st.store_cmd;
  assign move_start  = st.move;
  assign move_target = st.target;
  assign motor_halt  = st.halt;
  assign max_speed       = st.axis.max_speed;
  assign max_accel       = st.axis.max_accel;
  assign run_current     = st.axis.run_current;
  assign standby_current = st.axis.standby_current;

  logic              lcan;
  logic [3:0]        pos;
  logic              last;
  logic              discard;
  logic              bad_sum;
  logic [7:0]        status;
  logic [31:0]       rval;
  logic [7:0]        rsum;
  mci_pkg::mci_cmd_t c;

  always_comb begin
    lcan    = 1'b0;
    pos     = 4'h0;
    last    = 1'b0;
    discard = 1'b0;
    bad_sum = 1'b0;
    status  = mci_pkg::STATUS_OK;
    rval    = 32'h0000_0000;
    rsum    = 8'h00;
    c       = st.cmd;
    next_st = st;
    next_st.move  = 1'b0;
    next_st.halt  = 1'b0;
    next_st.store = 1'b0;
    case (st.phase)
      mci_pkg::MCI_RX: begin
        if (f_valid) begin
          lcan = (st.cnt == 4'h0) ? link_can : st.can;
          next_st.can = lcan;
          // can frames start at the code byte
          pos = lcan ? st.cnt + 4'h1 : st.cnt;
          next_st.frame[pos] = f_data;
          if (pos != mci_pkg::SUM_POS) begin
            next_st.sum = (st.cnt == 4'h0) ? f_data : st.sum + f_data;
          end
          last = lcan ? (pos == mci_pkg::CAN_LAST_POS) : (pos == mci_pkg::SERIAL_LAST_POS);
          if (last) begin
            next_st.cnt       = 4'h0;
            next_st.from_prog = 1'b0;
            next_st.phase     = mci_pkg::MCI_EXEC;
            // seven-byte core
            next_st.cmd.code  = next_st.frame[1];
            next_st.cmd.kind  = next_st.frame[2];
            next_st.cmd.bank  = next_st.frame[3];
            next_st.cmd.value = {next_st.frame[4], next_st.frame[5],
                                 next_st.frame[6], next_st.frame[7]};
          end else begin
            next_st.cnt = st.cnt + 4'h1;
          end
        end else if (prog_ready && prog_valid) begin
          next_st.cmd       = prog_cmd;
          next_st.from_prog = 1'b1;
          next_st.phase     = mci_pkg::MCI_EXEC;
        end
      end
      mci_pkg::MCI_EXEC: begin
        discard = !st.from_prog && !st.can && (st.frame[0] != module_addr);
        bad_sum = !st.from_prog && !st.can && (st.frame[8] != st.sum);
        rval    = c.value;
        if (discard) begin
          status = mci_pkg::STATUS_OK;
        end else if (bad_sum) begin
          status = mci_pkg::STATUS_CHECKSUM;
        end else if (!st.from_prog && store_mode) begin
          status            = mci_pkg::STATUS_STORED;
          next_st.store     = 1'b1;
          next_st.store_cmd = c;
        end else if (c.bank != 8'h00) begin
          status = mci_pkg::STATUS_NOT_AVAIL;
        end else if (c.code == SET_SETTING_CODE) begin
          if (settings_locked) begin
            status = mci_pkg::STATUS_LOCKED;
          end else begin
            case (c.kind)
              mci_pkg::SETTING_SPEED: begin
                if (c.value > mci_pkg::RAMP_MAX) begin
                  status = mci_pkg::STATUS_BAD_VALUE;
                end else begin
                  next_st.axis.max_speed = c.value[10:0];
                end
              end
              mci_pkg::SETTING_ACCEL: begin
                if (c.value > mci_pkg::RAMP_MAX) begin
                  status = mci_pkg::STATUS_BAD_VALUE;
                end else begin
                  next_st.axis.max_accel = c.value[10:0];
                end
              end
              mci_pkg::SETTING_RUN_CUR: begin
                if (c.value > mci_pkg::CURRENT_MAX) begin
                  status = mci_pkg::STATUS_BAD_VALUE;
                end else begin
                  next_st.axis.run_current = c.value[7:0];
                end
              end
              mci_pkg::SETTING_STBY_CUR: begin
                if (c.value > mci_pkg::CURRENT_MAX) begin
                  status = mci_pkg::STATUS_BAD_VALUE;
                end else begin
                  next_st.axis.standby_current = c.value[7:0];
                end
              end
              default: begin
                status = mci_pkg::STATUS_BAD_TYPE;
              end
            endcase
          end
        end else if (c.code == GET_SETTING_CODE) begin
          case (c.kind)
            mci_pkg::SETTING_SPEED: begin
              rval = {21'h000000, st.axis.max_speed};
            end
            mci_pkg::SETTING_ACCEL: begin
              rval = {21'h000000, st.axis.max_accel};
            end
            mci_pkg::SETTING_RUN_CUR: begin
              rval = {24'h000000, st.axis.run_current};
            end
            mci_pkg::SETTING_STBY_CUR: begin
              rval = {24'h000000, st.axis.standby_current};
            end
            default: begin
              status = mci_pkg::STATUS_BAD_TYPE;
            end
          endcase
        end else if (c.code == MOVE_CODE) begin
          next_st.move   = 1'b1;
          next_st.target = c.value;
        end else if (c.code == HALT_CODE) begin
          next_st.halt = 1'b1;
        end else begin
          status = mci_pkg::STATUS_BAD_CMD;
        end
        // build the reply image
        if (st.can) begin
          next_st.reply[0] = module_addr;
          next_st.reply[1] = status;
          next_st.reply[2] = c.code;
          next_st.reply[3] = rval[31:24];
          next_st.reply[4] = rval[23:16];
          next_st.reply[5] = rval[15:8];
          next_st.reply[6] = rval[7:0];
          next_st.reply[7] = 8'h00;
          next_st.reply[8] = 8'h00;
          next_st.rlen     = mci_pkg::CAN_REPLY_LEN;
        end else begin
          next_st.reply[0] = reply_addr;
          next_st.reply[1] = module_addr;
          next_st.reply[2] = status;
          next_st.reply[3] = c.code;
          next_st.reply[4] = rval[31:24];
          next_st.reply[5] = rval[23:16];
          next_st.reply[6] = rval[15:8];
          next_st.reply[7] = rval[7:0];
          for (int i = 0; i < 8; i++) begin
            rsum = rsum + next_st.reply[i];
          end
          next_st.reply[8] = rsum;
          next_st.rlen     = mci_pkg::SERIAL_REPLY_LEN;
        end
        if (discard || st.from_prog) begin
          next_st.phase = mci_pkg::MCI_RX;
          next_st.rlen  = 4'h0;
        end else begin
          next_st.phase = mci_pkg::MCI_TX;
          next_st.drive = 1'b1;
        end
      end
      mci_pkg::MCI_TX: begin
        if (tx_ready) begin
          next_st.reply = {8'h00, st.reply[8:1]};
          next_st.rlen  = st.rlen - 4'h1;
          if (st.rlen == 4'h1) begin
            next_st.phase = mci_pkg::MCI_RX;
            next_st.drive = 1'b0;
          end
        end
      end
      default: begin
        next_st.phase = mci_pkg::MCI_RX;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
      st.phase <= mci_pkg::MCI_RX;
      st.axis.max_speed       <= mci_pkg::SPEED_RESET;
      st.axis.max_accel       <= mci_pkg::ACCEL_RESET;
      st.axis.run_current     <= mci_pkg::RUN_CUR_RESET;
      st.axis.standby_current <= mci_pkg::STBY_CUR_RESET;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  property p_drive_only_reply;
    $rose(st.drive) |-> $past(st.phase) == mci_pkg::MCI_EXEC && !$past(st.from_prog);
  endproperty
  a_drive_only_reply: assert property (p_drive_only_reply)
    else $error("bus driven without a received command");

  property p_serial_len;
    $rose(st.drive) && !st.can |-> st.rlen == mci_pkg::SERIAL_REPLY_LEN;
  endproperty
  a_serial_len: assert property (p_serial_len)
    else $error("serial reply length wrong");

  property p_can_len;
    $rose(st.drive) && st.can |-> st.rlen == mci_pkg::CAN_REPLY_LEN && st.reply[0] == module_addr;
  endproperty
  a_can_len: assert property (p_can_len)
    else $error("can reply shape wrong");

  property p_bad_sum;
    st.phase == mci_pkg::MCI_EXEC && bad_sum && !discard
      |=> st.reply[2] == mci_pkg::STATUS_CHECKSUM && st.drive;
  endproperty
  a_bad_sum: assert property (p_bad_sum)
    else $error("checksum error not reported");

  property p_foreign_drop;
    st.phase == mci_pkg::MCI_EXEC && discard
      |=> st.phase == mci_pkg::MCI_RX && !st.drive && $stable(st.axis);
  endproperty
  a_foreign_drop: assert property (p_foreign_drop)
    else $error("foreign frame not dropped");

  property p_speed_write;
    st.phase == mci_pkg::MCI_EXEC && !discard && !bad_sum && !st.from_prog && !store_mode
      && !settings_locked && c.bank == 8'h00 && c.code == SET_SETTING_CODE
      && c.kind == mci_pkg::SETTING_SPEED && c.value <= mci_pkg::RAMP_MAX
      |=> st.axis.max_speed == $past(c.value[10:0]);
  endproperty
  a_speed_write: assert property (p_speed_write)
    else $error("speed setting not stored");

  property p_current_range;
    st.phase == mci_pkg::MCI_EXEC && !discard && !bad_sum && !store_mode && !settings_locked
      && c.bank == 8'h00 && c.code == SET_SETTING_CODE
      && c.kind == mci_pkg::SETTING_RUN_CUR && c.value > mci_pkg::CURRENT_MAX
      |=> $stable(st.axis.run_current) && (st.from_prog
          || st.reply[st.can ? 1 : 2] == mci_pkg::STATUS_BAD_VALUE);
  endproperty
  a_current_range: assert property (p_current_range)
    else $error("out of range current accepted");

  property p_prog_silent;
    st.phase == mci_pkg::MCI_EXEC && st.from_prog |=> st.phase == mci_pkg::MCI_RX && !st.drive;
  endproperty
  a_prog_silent: assert property (p_prog_silent)
    else $error("program command produced a reply");

  property p_reply_ends;
    st.drive && tx_ready && st.rlen == 4'h1 |=> !st.drive ##1 !st.drive;
  endproperty
  a_reply_ends: assert property (p_reply_ends)
    else $error("reply does not end after last byte");

  property p_stored;
    st.phase == mci_pkg::MCI_EXEC && !discard && !bad_sum && !st.from_prog && store_mode
      |=> st.store && st.drive && st.reply[st.can ? 1 : 2] == mci_pkg::STATUS_STORED;
  endproperty
  a_stored: assert property (p_stored)
    else $error("stored command not reported");

endmodule

// ### verification/mci_host.sv
// host model: builds command frames, sends them, takes replies
// assumes the bench calls its tasks at a falling clock edge
`timescale 1ns/1ps
module mci_host (
  input  wire logic       clock,
  input  wire logic       rx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            tx_ready
);
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tx_ready = 1'b0;
  end

  // address, seven byte core, additive sum; bad spoils the sum
  function automatic logic [71:0] frame(input logic [7:0] addr,
                                        input mci_pkg::mci_cmd_t c, input logic bad);
    logic [63:0] h;
    logic [7:0]  s;
    h = {addr, c};
    s = 8'h00;
    for (int i = 0; i < 8; i++) s = s + h[8*i +: 8];
    return {h, s ^ {7'h00, bad}};
  endfunction

  // bytes first..last; can frames send only the core
  task automatic push(input logic [71:0] f, input int first, input int last);
    for (int i = first; i <= last; i++) begin
      @(negedge clock);
      rx_valid = 1'b1;
      rx_data  = f[71-8*i -: 8];
      while (!rx_ready) @(negedge clock);
    end
    @(negedge clock);
    rx_valid = 1'b0;
    rx_data  = ~rx_data;
  endtask

  // takes n reply bytes, idling before each; next command waits for it
  task automatic take(input int n, input int stall, output logic [71:0] r);
    int w;
    r = '0;
    for (int i = 0; i < n; i++) begin
      if (stall > 0) begin
        tx_ready = 1'b0;
        repeat (stall) @(negedge clock);
      end
      tx_ready = 1'b1;
      w = 0;
      while (!tx_valid && w < 300) begin
        @(negedge clock);
        w++;
      end
      r = {r[63:0], tx_data};
      @(negedge clock);
    end
    tx_ready = 1'b0;
  endtask
endmodule

// ### verification/mci_interp_tb.sv
// self-checking bench for the command frame interpreter
// assumes the host model drives the byte stream at falling edges
`timescale 1ns/1ps
module mci_interp_tb;
  typedef struct packed {
    logic [3:0]        f;
    logic [7:0]        st;
    mci_pkg::mci_cmd_t c;
    logic [31:0]       rv;
  } mci_row_t;

  logic              clock, reset_n, rx_valid, rx_ready, tx_valid, tx_ready, bus_drive;
  logic              link_can, store_mode, settings_locked, prog_valid, prog_ready;
  logic              store_valid, move_start, motor_halt, drive_q;
  logic [7:0]        rx_data, tx_data, module_addr, reply_addr, run_current, standby_current;
  logic [10:0]       max_speed, max_accel;
  logic [31:0]       move_target;
  logic [37:0]       exp_set;
  logic [71:0]       got;
  mci_pkg::mci_cmd_t prog_cmd, store_cmd;
  mci_row_t          rows [20];
  int                num_errors, cmp_count, cycles, n_drive, n_rep, n_move, n_halt, n_store;

  mci_interp dut (
    .clock(clock), .reset_n(reset_n), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .bus_drive(bus_drive), .link_can(link_can), .module_addr(module_addr),
    .reply_addr(reply_addr), .store_mode(store_mode), .settings_locked(settings_locked),
    .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_cmd(prog_cmd),
    .store_valid(store_valid), .store_cmd(store_cmd), .move_start(move_start),
    .move_target(move_target), .motor_halt(motor_halt), .max_speed(max_speed),
    .max_accel(max_accel), .run_current(run_current), .standby_current(standby_current)
  );

  mci_host host (
    .clock(clock), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_ready(tx_ready)
  );

  always #25 clock = ~clock;

  always @(posedge clock) begin
    cycles++;
    n_drive += int'(bus_drive && !drive_q);
    drive_q = bus_drive;
    n_move += int'(move_start);
    n_halt += int'(motor_halt);
    n_store += int'(store_valid);
    if (cycles == 20000) begin
      num_errors++;
      results();
    end
  end

  task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // expected reply, serial or can
  function automatic logic [71:0] reply_of(input mci_row_t r);
    logic [71:0] e;
    e = {reply_addr, module_addr, r.st, r.c.code, r.rv, 8'h00};
    for (int i = 1; i < 9; i++) e[7:0] = e[7:0] + e[8*i +: 8];
    return r.f[3] ? {16'h0000, e[63:8]} : e;
  endfunction

  task automatic run_row(input mci_row_t r, input int stall);
    link_can        = r.f[3];
    store_mode      = r.f[2];
    settings_locked = r.f[1];
    if (r.f[3]) host.push(host.frame(module_addr, r.c, 1'b0), 1, 7);
    else host.push(host.frame(module_addr, r.c, r.f[0]), 0, 8);
    host.take(r.f[3] ? 7 : 9, stall, got);
    n_rep++;
    chk("reply", reply_of(r), got);
    if (r.st == 8'h64 && r.c.code == 8'h01)
      case (r.c.kind)
        8'h04: exp_set[37:27] = r.c.value[10:0];
        8'h05: exp_set[26:16] = r.c.value[10:0];
        8'h06: exp_set[15:8] = r.c.value[7:0];
        default: exp_set[7:0] = r.c.value[7:0];
      endcase
    chk("settings", 72'(exp_set),
        72'({max_speed, max_accel, run_current, standby_current}));
  endtask

  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    drive_q = 1'b0;
    link_can = 1'b0;
    store_mode = 1'b0;
    settings_locked = 1'b0;
    prog_valid = 1'b0;
    prog_cmd = '0;
    module_addr = 8'h2a;
    reply_addr = 8'h05;
    exp_set = '0;
    // flags: can, store, lock, bad sum
    rows = '{'{4'h0, 8'h64, '{8'h01, 8'h04, 8'h00, 32'h64}, 32'h64},
             '{4'h0, 8'h64, '{8'h01, 8'h05, 8'h00, 32'h7ff}, 32'h7ff},
             '{4'h0, 8'h64, '{8'h01, 8'h06, 8'h00, 32'hff}, 32'hff},
             '{4'h0, 8'h64, '{8'h01, 8'h07, 8'h00, 32'h12}, 32'h12},
             '{4'h0, 8'h04, '{8'h01, 8'h04, 8'h00, 32'h800}, 32'h800},
             '{4'h0, 8'h04, '{8'h01, 8'h07, 8'h00, 32'h100}, 32'h100},
             '{4'h0, 8'h03, '{8'h01, 8'h08, 8'h00, 32'h1}, 32'h1},
             '{4'h0, 8'h64, '{8'h02, 8'h04, 8'h00, 32'h0}, 32'h64},
             '{4'h0, 8'h64, '{8'h02, 8'h06, 8'h00, 32'h0}, 32'hff},
             '{4'h0, 8'h03, '{8'h02, 8'h09, 8'h00, 32'h0}, 32'h0},
             '{4'h0, 8'h06, '{8'h01, 8'h04, 8'h01, 32'h5}, 32'h5},
             '{4'h0, 8'h02, '{8'h09, 8'h00, 8'h00, 32'h7}, 32'h7},
             '{4'h1, 8'h01, '{8'h01, 8'h04, 8'h00, 32'h9}, 32'h9},
             '{4'h2, 8'h05, '{8'h01, 8'h04, 8'h00, 32'ha}, 32'ha},
             '{4'h4, 8'h65, '{8'h01, 8'h04, 8'h00, 32'hb}, 32'hb},
             '{4'h8, 8'h64, '{8'h01, 8'h05, 8'h00, 32'h33}, 32'h33},
             '{4'h0, 8'h64, '{8'h03, 8'h00, 8'h00, 32'h12345678}, 32'h12345678},
             '{4'h0, 8'h64, '{8'h04, 8'h00, 8'h00, 32'h0}, 32'h0},
             '{4'h8, 8'h64, '{8'h02, 8'h05, 8'h00, 32'h0}, 32'h33},
             '{4'h0, 8'h04, '{8'h01, 8'h06, 8'h00, 32'h100}, 32'h100}};
    repeat (16) @(posedge clock);
    @(negedge clock);
    reset_n = 1'b1;
    for (int i = 0; i < 20; i++) run_row(rows[i], i % 3);
    chk("pulses", 72'h010101, 72'({n_move[7:0], n_halt[7:0], n_store[7:0]}));
    chk("stored", 72'(rows[14].c), 72'(store_cmd));
    chk("target", 72'h12345678, 72'(move_target));
    // foreign address: dropped, then the next frame still parses
    link_can = 1'b0;
    host.push(host.frame(module_addr ^ 8'h01, rows[1].c, 1'b0), 0, 8);
    repeat (20) @(negedge clock);
    chk("foreign", 72'(n_rep), 72'(n_drive));
    run_row(rows[7], 0);
    // stored program entry: applied, no reply
    prog_cmd = '{8'h01, 8'h06, 8'h00, 32'h44};
    prog_valid = 1'b1;
    while (!prog_ready) @(negedge clock);
    @(negedge clock);
    prog_valid = 1'b0;
    exp_set[15:8] = 8'h44;
    repeat (3) @(negedge clock);
    chk("program", 72'(exp_set), 72'({max_speed, max_accel, run_current, standby_current}));
    chk("program drive", 72'(n_rep), 72'(n_drive));
    // second frame sent early on purpose while the reply stalls
    host.push(host.frame(module_addr, rows[7].c, 1'b0), 0, 8);
    repeat (4) @(negedge clock);
    host.push(host.frame(module_addr, rows[7].c, 1'b0), 0, 7);
    chk("fifo full", 72'h0, 72'(rx_ready));
    host.take(9, 2, got);
    chk("stalled reply", reply_of(rows[7]), got);
    host.push(host.frame(module_addr, rows[7].c, 1'b0), 8, 8);
    host.take(9, 0, got);
    chk("queued reply", reply_of(rows[7]), got);
    n_rep += 2;
    chk("drained", 72'h3, 72'({rx_ready, prog_ready}));
    // reset in mid-run clears settings and all checked outputs but rx_ready, which reads high
    reset_n = 1'b0;
    @(negedge clock);
    chk("reset state", 72'({1'b1, 43'h0}), 72'({rx_ready, tx_valid, bus_drive, store_valid,
        move_start, motor_halt, max_speed, max_accel, run_current, standby_current}));
    reset_n = 1'b1;
    exp_set = '0;
    run_row(rows[0], 1);
    chk("replies", 72'(n_rep), 72'(n_drive));
    results();
  end
endmodule
